/* File: hdl/sbss_top.sv */
// Servo brake and stop sequencer: holding-brake, motor-power and stop-method control.
// Assumes an AXI4-Lite master on clk_i, alarm and speed from logic on the same clock.
// Contract
// - Class-two alarm selector picks stop method, after-state.
// - Warning mode runs on; alarm still needs reset.
// - Reverse brake decelerates under torque limit.
// - Reverse torque limit 0-350%, applies at once.
// - Applied torque never exceeds motor maximum.
// - Brake output on releases; off at servo-off/alarm.
// - Brake output unrouted by default; value 4 routes.
// - Stopped servo-off: brake off, power after delay.
// - Positive servo-on wait: brake first, power later.
// - Negative servo-on wait: power first, brake later.
// - Alarm removes motor power immediately.
// - Running stop: brake once speed below threshold.
// - Running stop: brake also after wait expires.
`include "sbss_defs.svh"
module sbss_top
  import sbss_pkg::*;
#(
  parameter int TICK_CYCLES = `SBSS_TICK_CYCLES
) (
  input wire logic clk_i, // 40 MHz clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic clk_en_i, // Freezes all state when low
  input wire logic alarm_i, // Class-two alarm condition
  input wire logic [15:0] motor_speed_i, // Speed magnitude, rpm
  input wire logic [9:0] motor_max_torque_i, // Motor max torque, % rated
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic motor_power_o, // Power stage enabled
  output logic dyn_brake_o, // Dynamic brake engaged
  output logic reverse_brake_o, // Reverse-brake deceleration active
  output logic [9:0] torque_limit_o, // Reverse-brake torque cap, %
  output logic brake_pair1_o, // Brake release on output pair one
  output logic brake_pair2_o, // Brake release on output pair two
  output logic alarm_active_o // Alarm latched, awaiting reset
);

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  function automatic logic [15:0] ms_of_10ms(input logic [8:0] v);
    return 16'(v) * 16'(`SBSS_UNIT_10MS);
  endfunction : ms_of_10ms

  // Bus slave state
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Software registers
  logic [2:0] ctrl_reg;
  logic [2:0] stop_sel_reg, stop_sel_act_reg;
  logic [9:0] rb_torque_reg;
  logic [11:0] son_wait_reg;
  logic [8:0] soff_wait_reg;
  logic [6:0] speed_thr_reg, brake_wait_reg;
  logic [7:0] out_assign_reg;

  // Sequencer state
  sbss_state_e state_reg, state_next;
  logic son_prev_reg, alarm_latched_reg, power_reg, brake_reg, db_reg, rb_reg;
  logic [15:0] timer_reg, timer_next;
  logic timer_load;
  logic [31:0] tick_cnt_reg;
  logic power_next, brake_next, db_next, rb_next;

  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [31:0] wr_data = w_data_reg;
  wire wr_ctrl = wr_fire && (aw_addr_reg == `SBSS_OFF_CTRL);
  wire wr_hit = (aw_addr_reg <= `SBSS_OFF_OUT_ASSIGN) && (aw_addr_reg[1:0] == 2'h0);
  wire rd_fire = s_axi_arvalid && !rvalid_reg;
  wire rd_hit = (s_axi_araddr <= `SBSS_OFF_STATUS) && (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] wr_merged = strb_merge(32'h0, wr_data, w_strb_reg);
  wire alm_rst_pulse = wr_ctrl && w_strb_reg[0] && wr_data[`SBSS_CTRL_ALM_RST_BIT];
  wire restart_pulse = wr_ctrl && w_strb_reg[0] && wr_data[`SBSS_CTRL_RESTART_BIT];

  // Effective parameters, clamped into their legal ranges
  wire [9:0] rb_lim_eff = (rb_torque_reg > `SBSS_MAX_RB_TORQUE) ? `SBSS_MAX_RB_TORQUE : rb_torque_reg;
  wire [9:0] torque_cap = (rb_lim_eff > motor_max_torque_i) ? motor_max_torque_i : rb_lim_eff;
  wire son_neg = son_wait_reg[11];
  wire [11:0] son_mag_raw = son_neg ? 12'(-son_wait_reg) : son_wait_reg;
  wire [11:0] son_mag = (son_mag_raw > `SBSS_MAX_SON_WAIT) ? `SBSS_MAX_SON_WAIT : son_mag_raw;
  wire [8:0] soff_eff = (soff_wait_reg > `SBSS_MAX_SOFF_WAIT) ? `SBSS_MAX_SOFF_WAIT : soff_wait_reg;
  wire [6:0] thr_eff = (speed_thr_reg < `SBSS_MIN_SPEED_THR) ? `SBSS_MIN_SPEED_THR :
                       (speed_thr_reg > `SBSS_MAX_SPEED_THR) ? `SBSS_MAX_SPEED_THR : speed_thr_reg;
  wire stopped = motor_speed_i < 16'(thr_eff);
  wire son_cmd = ctrl_reg[`SBSS_CTRL_SON_BIT];
  wire son_rise = son_cmd && !son_prev_reg;
  wire son_fall = !son_cmd && son_prev_reg;
  wire warn_mode = (stop_sel_act_reg == SBSS_SEL_WARN);
  wire alarm_stop = (alarm_i || alarm_latched_reg) && !warn_mode;
  wire sel_rb = (stop_sel_act_reg == SBSS_SEL_RB_DB) || (stop_sel_act_reg == SBSS_SEL_RB_COAST);
  wire sel_db = (stop_sel_act_reg == SBSS_SEL_DB_COAST) || (stop_sel_act_reg == SBSS_SEL_DB_DB);
  wire hold_db = (stop_sel_act_reg == SBSS_SEL_DB_DB) || (stop_sel_act_reg == SBSS_SEL_RB_DB);
  wire tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  wire timer_done = (timer_reg == 16'h0);

  // Bus slave: address and data taken independently, response after both
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= 3'h0;
      stop_sel_reg <= `SBSS_RST_STOP_SEL;
      rb_torque_reg <= `SBSS_RST_RB_TORQUE;
      son_wait_reg <= `SBSS_RST_SON_WAIT;
      soff_wait_reg <= `SBSS_RST_SOFF_WAIT;
      speed_thr_reg <= `SBSS_RST_SPEED_THR;
      brake_wait_reg <= `SBSS_RST_BRAKE_WAIT;
      out_assign_reg <= 8'h00;
    end else if (clk_en_i && wr_fire) begin
      case (aw_addr_reg)
        `SBSS_OFF_CTRL: ctrl_reg <= 3'(strb_merge(32'(ctrl_reg), wr_data, w_strb_reg) & 32'h1);
        `SBSS_OFF_STOP_SEL: stop_sel_reg <= wr_merged[2:0] > 3'h5 ? 3'h5 : wr_merged[2:0];
        `SBSS_OFF_RB_TORQUE: rb_torque_reg <= 10'(strb_merge(32'(rb_torque_reg), wr_data, w_strb_reg));
        `SBSS_OFF_SON_WAIT: son_wait_reg <= 12'(strb_merge(32'(son_wait_reg), wr_data, w_strb_reg));
        `SBSS_OFF_SOFF_WAIT: soff_wait_reg <= 9'(strb_merge(32'(soff_wait_reg), wr_data, w_strb_reg));
        `SBSS_OFF_SPEED_THR: speed_thr_reg <= 7'(strb_merge(32'(speed_thr_reg), wr_data, w_strb_reg));
        `SBSS_OFF_BRAKE_WAIT: brake_wait_reg <= 7'(strb_merge(32'(brake_wait_reg), wr_data, w_strb_reg));
        `SBSS_OFF_OUT_ASSIGN: out_assign_reg <= 8'(strb_merge(32'(out_assign_reg), wr_data, w_strb_reg));
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  wire [31:0] status_word = {18'h0, alarm_latched_reg, stop_sel_act_reg, power_reg, brake_reg, db_reg, rb_reg,
                             state_reg};
  wire [31:0] rd_mux =
    (s_axi_araddr == `SBSS_OFF_CTRL) ? 32'(ctrl_reg) :
    (s_axi_araddr == `SBSS_OFF_STOP_SEL) ? 32'(stop_sel_reg) :
    (s_axi_araddr == `SBSS_OFF_RB_TORQUE) ? 32'(rb_torque_reg) :
    (s_axi_araddr == `SBSS_OFF_SON_WAIT) ? 32'(son_wait_reg) :
    (s_axi_araddr == `SBSS_OFF_SOFF_WAIT) ? 32'(soff_wait_reg) :
    (s_axi_araddr == `SBSS_OFF_SPEED_THR) ? 32'(speed_thr_reg) :
    (s_axi_araddr == `SBSS_OFF_BRAKE_WAIT) ? 32'(brake_wait_reg) :
    (s_axi_araddr == `SBSS_OFF_OUT_ASSIGN) ? 32'(out_assign_reg) :
    (s_axi_araddr == `SBSS_OFF_STATUS) ? status_word : 32'h0;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else if (clk_en_i) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_hit ? rd_mux : 32'h0;
        rresp_reg <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Selector and alarm latch; selector only takes effect on restart
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_sel_act_reg <= `SBSS_RST_STOP_SEL;
      alarm_latched_reg <= 1'b0;
      son_prev_reg <= 1'b0;
    end else if (clk_en_i) begin
      son_prev_reg <= son_cmd;
      if (restart_pulse) begin
        stop_sel_act_reg <= stop_sel_reg;
      end
      // Live alarm beats a reset request in the same cycle
      if (alarm_i) begin
        alarm_latched_reg <= 1'b1;
      end else if (alm_rst_pulse) begin
        alarm_latched_reg <= 1'b0;
      end
    end
  end

  // Millisecond tick, restarted with every timer load
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= 32'h0;
      timer_reg <= 16'h0;
    end else if (clk_en_i) begin
      tick_cnt_reg <= (timer_load || tick) ? 32'h0 : tick_cnt_reg + 32'h1;
      timer_reg <= timer_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    power_next = power_reg;
    brake_next = brake_reg;
    db_next = db_reg;
    rb_next = rb_reg;
    timer_load = 1'b0;
    timer_next = (tick && !timer_done) ? timer_reg - 16'h1 : timer_reg;
    case (state_reg)
      SBSS_OFF, SBSS_HOLD: begin
        if (son_rise && !alarm_stop) begin
          timer_load = 1'b1;
          timer_next = 16'(son_mag);
          db_next = 1'b0;
          state_next = (son_mag == 12'h0) ? SBSS_RUN : SBSS_SON_WAIT;
          brake_next = (son_mag == 12'h0) || !son_neg;
          power_next = (son_mag == 12'h0) || son_neg;
        end
      end
      SBSS_SON_WAIT: begin
        if (alarm_stop || !son_cmd) begin
          power_next = 1'b0;
          brake_next = 1'b0;
          state_next = SBSS_OFF;
        end else if (timer_done) begin
          power_next = 1'b1;
          brake_next = 1'b1;
          state_next = SBSS_RUN;
        end
      end
      SBSS_RUN: begin
        if (alarm_stop || son_fall) begin
          if (alarm_stop) begin
            power_next = 1'b0;
          end
          if (stopped) begin
            brake_next = 1'b0;
            if (alarm_stop) begin
              db_next = hold_db;
              state_next = SBSS_HOLD;
            end else begin
              timer_load = 1'b1;
              timer_next = ms_of_10ms(soff_eff);
              state_next = SBSS_SOFF_DELAY;
            end
          end else begin
            power_next = 1'b0;
            timer_load = 1'b1;
            timer_next = ms_of_10ms(9'(brake_wait_reg));
            db_next = alarm_stop && sel_db;
            rb_next = alarm_stop && sel_rb;
            state_next = SBSS_STOPPING;
          end
        end
      end
      SBSS_SOFF_DELAY: begin
        if (alarm_stop || timer_done) begin
          power_next = 1'b0;
          state_next = SBSS_OFF;
        end
      end
      SBSS_STOPPING: begin
        if (stopped || timer_done) begin
          brake_next = 1'b0;
          rb_next = 1'b0;
          db_next = alarm_stop && hold_db;
          state_next = alarm_stop ? SBSS_HOLD : SBSS_OFF;
        end
      end
      default: begin
        power_next = 1'b0;
        brake_next = 1'b0;
        state_next = SBSS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= SBSS_OFF;
      power_reg <= 1'b0;
      brake_reg <= 1'b0;
      db_reg <= 1'b0;
      rb_reg <= 1'b0;
      torque_limit_o <= 10'h0;
      brake_pair1_o <= 1'b0;
      brake_pair2_o <= 1'b0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      power_reg <= power_next;
      brake_reg <= brake_next;
      db_reg <= db_next;
      rb_reg <= rb_next;
      torque_limit_o <= torque_cap;
      brake_pair1_o <= brake_next && (out_assign_reg[3:0] == `SBSS_OUT_SEL_BRAKE);
      brake_pair2_o <= brake_next && (out_assign_reg[7:4] == `SBSS_OUT_SEL_BRAKE);
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign motor_power_o = power_reg;
  assign dyn_brake_o = db_reg;
  assign reverse_brake_o = rb_reg;
  assign alarm_active_o = alarm_latched_reg;

  // Checks
  alarm_power_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && alarm_stop && state_reg == SBSS_RUN) |=> !motor_power_o) else $error("power kept on alarm");
  off_brake_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_reg == SBSS_OFF || state_reg == SBSS_HOLD) |-> !brake_reg) else $error("brake released while off");
  torque_cap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    torque_limit_o <= 10'h15E) else $error("torque cap above range");
  motor_max_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i |=> torque_limit_o <= $past(motor_max_torque_i))
    else $error("torque above motor max");
  warn_run_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && warn_mode && alarm_i && son_cmd && state_reg == SBSS_RUN && !restart_pulse)
    |=> state_reg == SBSS_RUN && alarm_active_o) else $error("warning mode stopped");
  son_pos_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_reg == SBSS_OFF && son_rise && !alarm_stop && !son_neg && son_mag != 12'h0)
    |=> brake_reg && !motor_power_o) else $error("positive wait order");
  son_neg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_reg == SBSS_OFF && son_rise && !alarm_stop && son_neg && son_mag != 12'h0)
    |=> !brake_reg && motor_power_o) else $error("negative wait order");
  stop_soff_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_reg == SBSS_RUN && son_fall && stopped && !alarm_stop)
    |=> !brake_reg && motor_power_o) else $error("stopped servo-off order");
  speed_brake_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_reg == SBSS_STOPPING && stopped) |=> !brake_reg) else $error("brake late on speed");
  rb_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reverse_brake_o |-> sel_rb && !motor_power_o) else $error("reverse brake wrong mode");
  pair_route_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    brake_pair1_o |-> brake_reg && out_assign_reg[3:0] == 4'h4) else $error("pair one misrouted");
  run_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) state_reg == SBSS_SON_WAIT ##1 state_reg == SBSS_RUN);
  stop_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) state_reg == SBSS_STOPPING && timer_done);
  hold_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) state_reg == SBSS_HOLD && dyn_brake_o);
endmodule : sbss_top

/* File: hdl/sbss_defs.svh */
// Register offsets, reset values and timing constants of the brake/stop sequencer.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SBSS_DEFS_SVH
`define SBSS_DEFS_SVH
`define SBSS_OFF_CTRL 8'h00
`define SBSS_OFF_STOP_SEL 8'h04
`define SBSS_OFF_RB_TORQUE 8'h08
`define SBSS_OFF_SON_WAIT 8'h0C
`define SBSS_OFF_SOFF_WAIT 8'h10
`define SBSS_OFF_SPEED_THR 8'h14
`define SBSS_OFF_BRAKE_WAIT 8'h18
`define SBSS_OFF_OUT_ASSIGN 8'h1C
`define SBSS_OFF_STATUS 8'h20
`define SBSS_CTRL_SON_BIT 0
`define SBSS_CTRL_ALM_RST_BIT 1
`define SBSS_CTRL_RESTART_BIT 2
`define SBSS_RST_STOP_SEL 3'h0
`define SBSS_RST_RB_TORQUE 10'h12C
`define SBSS_MAX_RB_TORQUE 10'h15E
`define SBSS_RST_SON_WAIT 12'h000
`define SBSS_MAX_SON_WAIT 12'h7D0
`define SBSS_RST_SOFF_WAIT 9'h000
`define SBSS_MAX_SOFF_WAIT 9'h1F4
`define SBSS_RST_SPEED_THR 7'h64
`define SBSS_MIN_SPEED_THR 7'h0A
`define SBSS_MAX_SPEED_THR 7'h64
`define SBSS_RST_BRAKE_WAIT 7'h32
`define SBSS_OUT_SEL_BRAKE 4'h4
`define SBSS_CLK_PERIOD_NS 25
`define SBSS_TICK_NS 1000000
`define SBSS_TICK_CYCLES (`SBSS_TICK_NS / `SBSS_CLK_PERIOD_NS)
`define SBSS_UNIT_10MS 10
`endif

/* File: hdl/sbss_pkg.sv */
// Types of the brake/stop sequencer.
// Assumes nothing beyond the constants header.
package sbss_pkg;
  `include "sbss_defs.svh"

  typedef enum logic [5:0] {
    SBSS_OFF = 6'h01,
    SBSS_SON_WAIT = 6'h02,
    SBSS_RUN = 6'h04,
    SBSS_SOFF_DELAY = 6'h08,
    SBSS_STOPPING = 6'h10,
    SBSS_HOLD = 6'h20
  } sbss_state_e;

  typedef enum logic [2:0] {
    SBSS_SEL_DB_COAST = 3'h0,
    SBSS_SEL_DB_DB = 3'h1,
    SBSS_SEL_COAST = 3'h2,
    SBSS_SEL_RB_DB = 3'h3,
    SBSS_SEL_RB_COAST = 3'h4,
    SBSS_SEL_WARN = 3'h5
  } sbss_stop_sel_e;
endpackage : sbss_pkg

/* File: dv/sbss_host_model.sv */
// Far-side model: host motion reference and motor with holding brake.
// Assumes power and brake release from the sequencer, one clock domain.
module sbss_host_model #(
  parameter int TICK_CYCLES = 4,
  parameter int RELEASE_MS = 2
) (
  input wire logic clk_i, // Clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic power_i, // Motor power on
  input wire logic release_i, // Brake release output
  input wire logic [15:0] target_i, // Commanded speed, rpm
  input wire logic hold_i, // External force keeps motor turning
  output logic [15:0] speed_o // Motor speed, rpm
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 0;
      speed_o <= 16'h0000;
    end else if (power_i && release_i) begin
      if (wait_cnt < (50 + RELEASE_MS) * TICK_CYCLES) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        speed_o <= target_i;
      end
    end else begin
      wait_cnt <= 0;
      // Unpowered motor coasts down unless the load drives it
      if (!power_i && !hold_i) begin
        speed_o <= (speed_o > 16'h0002) ? speed_o - 16'h0002 : 16'h0000;
      end
    end
  end
endmodule : sbss_host_model

/* File: dv/sbss_top_tb.sv */
// Self-checking bench of the brake and stop sequencer.
// Assumes a 4-clock millisecond tick; the host model drives motor speed.
module sbss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_n_i, alarm_i, aw_v, w_v, b_r, ar_v, r_r;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [1:0] b_s, r_s;
  logic aw_r, w_r, b_v, ar_r, r_v, pwr, db, rb, p1, p2, alm, hold;
  logic [9:0] tq, mt;
  logic [15:0] spd, tgt;
  logic [5:0] obs;
  int fails, cmp_count, cyc, seed, i;
  logic [9:0] v;
  assign obs = {db, alm, rb, p2, p1, pwr};
  sbss_top #(.TICK_CYCLES(4)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .alarm_i(alarm_i),
    .motor_speed_i(spd), .motor_max_torque_i(mt), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .motor_power_o(pwr), .dyn_brake_o(db), .reverse_brake_o(rb), .torque_limit_o(tq),
    .brake_pair1_o(p1), .brake_pair2_o(p2), .alarm_active_o(alm));
  sbss_host_model #(.TICK_CYCLES(4), .RELEASE_MS(2)) host (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .power_i(pwr), .release_i(p1 | p2), .target_i(tgt), .hold_i(hold), .speed_o(spd));
  always #12.5 clk_i = ~clk_i;
  task finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc++;
    // Whole sequence needs about 2000 cycles
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_i);
      if (!aw && aw_r === 1'b1) begin
        aw = 1;
        aw_v <= 1'b0;
      end
      if (!w && w_r === 1'b1) begin
        w = 1;
        w_v <= 1'b0;
      end
    end
    do @(posedge clk_i); while (b_v !== 1'b1);
    chk({30'h0, b_s}, {30'h0, (a <= 8'h1C && a[1:0] == 2'h0) ? 2'b00 : 2'b10});
    b_r <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge clk_i); while (ar_r !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge clk_i); while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(r_d, e);
    chk({30'h0, r_s}, {30'h0, er});
  endtask : rd
  // Counts edges until output k shows level lv and checks the count window
  task wait_sig(input int k, input logic lv, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (obs[k] !== lv && n <= hi) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp_count++;
    if (obs[k] !== lv || n < lo || n > hi) begin
      fails++;
      $display("[FAIL] %0t: output %0d after %0d cycles", $time, k, n);
    end
  endtask : wait_sig
  function automatic logic [9:0] exp_tq(input logic [9:0] lim, input logic [9:0] mx);
    logic [9:0] c;
    c = (lim > 10'h15E) ? 10'h15E : lim;
    return (c < mx) ? c : mx;
  endfunction : exp_tq
  initial begin
    clk_i = 0;
    reset_n_i = 0;
    {alarm_i, aw_v, w_v, b_r, ar_v, r_r, hold} = '0;
    {aw_a, ar_a, w_d} = '0;
    mt = 10'h190;
    tgt = 16'h0000;
    seed = 5310;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    chk({26'h0, obs}, 32'h0);
    rd(8'h04, 32'h0, 2'b00);
    rd(8'h08, 32'h12C, 2'b00);
    rd(8'h0C, 32'h0, 2'b00);
    rd(8'h10, 32'h0, 2'b00);
    rd(8'h14, 32'h64, 2'b00);
    rd(8'h18, 32'h32, 2'b00);
    rd(8'h1C, 32'h0, 2'b00);
    rd(8'h24, 32'h0, 2'b10);
    wr(8'h20, 32'h0);
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 10'h15F : (i == 1) ? 10'h15E : 10'({$random(seed)} % 400);
      @(posedge clk_i);
      mt <= (i < 2) ? 10'h3FF : 10'({$random(seed)} % 400);
      wr(8'h08, {22'h0, v});
      repeat (3) @(posedge clk_i);
      chk({22'h0, tq}, {22'h0, exp_tq(v, mt)});
    end
    wr(8'h1C, 32'h40);
    wr(8'h0C, 32'h2);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1);
    wait_sig(2, 1'b1, 0, 3);
    chk({31'h0, pwr}, 32'h0);
    wait_sig(0, 1'b1, 6, 12);
    chk({31'h0, p1}, 32'h0);
    wr(8'h00, 32'h0);
    wait_sig(2, 1'b0, 0, 3);
    wait_sig(0, 1'b0, 34, 46);
    wr(8'h1C, 32'h44);
    wr(8'h0C, 32'hFFE);
    wr(8'h00, 32'h1);
    wait_sig(0, 1'b1, 0, 3);
    chk({31'h0, p1}, 32'h0);
    wait_sig(1, 1'b1, 6, 12);
    @(posedge clk_i);
    alarm_i <= 1'b1;
    wait_sig(0, 1'b0, 0, 3);
    chk({30'h0, p2, alm}, 32'h1);
    alarm_i <= 1'b0;
    wr(8'h00, 32'h2);
    wait_sig(4, 1'b0, 0, 3);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h5);
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h1);
    wait_sig(0, 1'b1, 0, 3);
    @(posedge clk_i);
    alarm_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    alarm_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({30'h0, pwr, alm}, 32'h3);
    wr(8'h00, 32'h3);
    wait_sig(4, 1'b0, 0, 3);
    wr(8'h00, 32'h0);
    wait_sig(0, 1'b0, 0, 46);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h4);
    tgt <= 16'h0096;
    wr(8'h00, 32'h1);
    repeat (240) @(posedge clk_i);
    alarm_i <= 1'b1;
    wait_sig(3, 1'b1, 0, 3);
    chk({31'h0, pwr}, 32'h0);
    wait_sig(1, 1'b0, 20, 34);
    wait_sig(5, 1'b1, 0, 3);
    alarm_i <= 1'b0;
    wr(8'h00, 32'h2);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h1);
    repeat (240) @(posedge clk_i);
    hold <= 1'b1;
    wr(8'h00, 32'h0);
    wait_sig(0, 1'b0, 0, 3);
    wait_sig(1, 1'b0, 34, 46);
    chk({30'h0, db, rb}, 32'h0);
    // Selectors 1, 4, 2 with a different value left pending after restart
    for (i = 0; i < 3; i++) begin
      hold <= 1'b0;
      alarm_i <= 1'b0;
      wr(8'h00, 32'h2);
      wr(8'h04, (i == 0) ? 32'h1 : (i == 1) ? 32'h4 : 32'h2);
      wr(8'h00, 32'h4);
      wr(8'h04, 32'h3);
      wr(8'h00, 32'h1);
      repeat (240) @(posedge clk_i);
      alarm_i <= 1'b1;
      wait_sig(0, 1'b0, 0, 3);
      chk({30'h0, db, rb}, (i == 0) ? 32'h2 : (i == 1) ? 32'h1 : 32'h0);
      wait_sig(1, 1'b0, 0, 46);
      chk({31'h0, db}, (i == 0) ? 32'h1 : 32'h0);
    end
    finish_test();
  end
endmodule : sbss_top_tb
